// ===== shared/pmd_pkg.sv
// Package: constants and types for the power mode direct transition block.
package pmd_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] PMD_OFF_CTRL = 8'h00;
  localparam logic [7:0] PMD_OFF_HALT1 = 8'h04;
  localparam logic [7:0] PMD_OFF_HALT2 = 8'h08;
  localparam logic [7:0] PMD_OFF_SLEEP = 8'h0c;
  localparam logic [7:0] PMD_OFF_MODE = 8'h10;
  localparam logic [7:0] PMD_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] PMD_OFF_IRQ_MASK = 8'h18;
  // Control register field positions.
  localparam int PMD_BIT_STANDBY_SELECT = 0;
  localparam int PMD_BIT_LOW_SPEED_ON = 1;
  localparam int PMD_BIT_TIMER_WATCH_SELECT = 2;
  localparam int PMD_BIT_DIRECT_TRANSITION_ON = 3;
  localparam int PMD_BIT_MEDIUM_SPEED_ON = 4;
  localparam int PMD_POS_OSC_WAIT = 5;
  localparam int PMD_OSC_WAIT_W = 3;
  // Reset values.
  localparam logic [7:0] PMD_CTRL_RST = 8'h00;
  localparam logic [7:0] PMD_HALT_RST = 8'hff;
  // Interrupt status layout: transition done, standby wake, then captured inputs.
  localparam int PMD_IRQ_DONE = 0;
  localparam int PMD_IRQ_WAKE = 1;
  localparam int PMD_IRQ_CAP = 2;
  // Number of filtered inputs: two requests, eight wake-up inputs, event counter.
  localparam int PMD_NUM_INPUTS = 11;
  localparam int PMD_IRQ_W = PMD_IRQ_CAP + PMD_NUM_INPUTS;
  // State counts of a transition, in states of the running clock.
  localparam logic [4:0] PMD_SLEEP_STATES = 5'h02;
  localparam logic [4:0] PMD_INTERNAL_STATES = 5'h01;
  localparam logic [4:0] PMD_EXCEPTION_STATES = 5'h0e;
  // Least level width, in internal clock cycles, for a captured input.
  localparam int PMD_MIN_LEVEL = 2;
  // Clock periods in oscillator cycles: high speed, medium speed, subclock.
  localparam logic [7:0] PMD_PER_HIGH = 8'h02;
  localparam logic [7:0] PMD_PER_MED = 8'h10;
  localparam logic [7:0] PMD_PER_SUB = 8'h40;
  // Oscillator wait base, in states; the select field shifts it left.
  localparam int PMD_OSC_WAIT_BASE = 8192;
  localparam int PMD_WAIT_W = 24;
  // Operating modes shown to software.
  typedef enum logic [2:0] {
    PMD_MODE_HIGH = 3'h0,
    PMD_MODE_MED = 3'h1,
    PMD_MODE_SUB = 3'h2,
    PMD_MODE_STANDBY = 3'h3
  } pmd_mode_e;
  // Transition sequencer states, Gray coded from run through sleep, watch and oscillator wait to exception.
  typedef enum logic [2:0] {
    PMD_ST_RUN = 3'b000,
    PMD_ST_SLEEP = 3'b001,
    PMD_ST_WATCH = 3'b011,
    PMD_ST_OSC = 3'b010,
    PMD_ST_EXC = 3'b110,
    PMD_ST_STANDBY = 3'b111
  } pmd_state_e;
endpackage : pmd_pkg

// ===== src/pmd_level_capture.sv
// Module: level-width filter and falling edge capture for one external input.
module pmd_level_capture
  import pmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic pin_in,
  output logic level,
  output logic fall
);
  import pmd_pkg::*;

  logic [1:0] samples;
  logic stable_low;
  logic stable_high;

  // Sampling advances only on internal clock ticks, so a stopped clock freezes it.
  assign stable_high = samples[0] & samples[1];
  assign stable_low = ~samples[0] & ~samples[1];

  // A level counts only after two ticks; a short high therefore yields no fall.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      samples <= 2'h3;
      level <= 1'b1;
      fall <= 1'b0;
    end else begin
      fall <= 1'b0;
      if (tick) begin
        samples <= {samples[0], pin_in};
        if (stable_high) begin
          level <= 1'b1;
        end else if (stable_low && level) begin
          level <= 1'b0;
          fall <= 1'b1;
        end
      end
    end
  end
endmodule : pmd_level_capture

// ===== src/pmd_power_mode.sv
// Module: power mode sequencer, module clock halts and input capture with APB registers.
// Behaviour
// - Medium to high: sleep states at old period, exception states at new period.
// - From subactive: sleep states at subclock, then oscillator wait plus exception states.
// - Transitions into or out of subactive pass through watch with clocks stopped.
// - A cleared clock-halt bit stops that module's clock; setting it resumes.
// - Sleep in active with standby select, no low speed, no watch timer enters standby.
// - In standby, pins float except those with pull-up switched on.
// - A fall after a high shorter than two internal cycles is not captured.
// - Width checks cover two requests, eight wake-up inputs and event counter.
// - Sleep with direct transition on switches modes without stopping the program.
// - A finished direct transition starts its interrupt exception handling.
module pmd_power_mode
  import pmd_pkg::*;
#(
  parameter int OSC_WAIT_BASE = PMD_OSC_WAIT_BASE,
  parameter int NUM_PINS = 16,
  parameter int HALT_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] external_request,
  input wire logic [7:0] wakeup_input,
  input wire logic event_counter_request,
  input wire logic [NUM_PINS-1:0] pin_pullup_on,
  output logic [NUM_PINS-1:0] pin_float,
  output logic [2*HALT_W-1:0] module_clock_enable,
  output logic cpu_clock_enable,
  output logic cpu_running,
  output logic system_osc_on,
  output logic watch_active,
  output logic exception_start,
  output logic [2:0] mode,
  output logic irq
);
  import pmd_pkg::*;

  // Register storage.
  logic [7:0] system_control_first;
  logic [HALT_W-1:0] module_clock_halt_first;
  logic [HALT_W-1:0] module_clock_halt_second;
  logic [2*HALT_W-1:0] halt_applied;
  logic [PMD_IRQ_W-1:0] irq_status;
  logic [PMD_IRQ_W-1:0] irq_mask;
  pmd_mode_e cur_mode;
  pmd_mode_e target_mode;
  pmd_state_e state;
  pmd_state_e next_state;
  logic [PMD_WAIT_W-1:0] count;
  logic [7:0] div_count;
  logic [7:0] period;
  logic tick;
  logic [PMD_NUM_INPUTS-1:0] raw_inputs;
  logic [PMD_NUM_INPUTS-1:0] in_level;
  logic [PMD_NUM_INPUTS-1:0] in_fall;
  logic [PMD_NUM_INPUTS-1:0] last_raw;
  logic wake_pin;
  logic done_pulse;
  logic wake_pulse;

  // Control fields.
  wire standby_select = system_control_first[PMD_BIT_STANDBY_SELECT];
  wire low_speed_on = system_control_first[PMD_BIT_LOW_SPEED_ON];
  wire timer_watch_select = system_control_first[PMD_BIT_TIMER_WATCH_SELECT];
  wire direct_transition_on = system_control_first[PMD_BIT_DIRECT_TRANSITION_ON];
  wire medium_speed_on = system_control_first[PMD_BIT_MEDIUM_SPEED_ON];
  wire [PMD_OSC_WAIT_W-1:0] osc_wait_select =
    system_control_first[PMD_POS_OSC_WAIT +: PMD_OSC_WAIT_W];

  // APB decode; every access completes in its first access cycle.
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_ctrl = paddr == PMD_OFF_CTRL;
  wire hit_halt1 = paddr == PMD_OFF_HALT1;
  wire hit_halt2 = paddr == PMD_OFF_HALT2;
  wire hit_sleep = paddr == PMD_OFF_SLEEP;
  wire hit_mode = paddr == PMD_OFF_MODE;
  wire hit_stat = paddr == PMD_OFF_IRQ_STAT;
  wire hit_mask = paddr == PMD_OFF_IRQ_MASK;
  wire mapped = hit_ctrl | hit_halt1 | hit_halt2 | hit_sleep | hit_mode | hit_stat | hit_mask;
  wire sleep_cmd = wr & hit_sleep & pwdata[0];

  // Zero wait states: every register is a flip-flop, so no access ever needs a stall.
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Sleep decode: which transition a sleep request asks for in the current mode.
  wire in_active = (cur_mode == PMD_MODE_HIGH) | (cur_mode == PMD_MODE_MED);
  wire go_standby = in_active & standby_select & ~low_speed_on & ~timer_watch_select;
  wire go_act_act = in_active & direct_transition_on & ~standby_select & ~low_speed_on
    & ((cur_mode == PMD_MODE_HIGH) == medium_speed_on);
  wire go_to_sub = in_active & direct_transition_on & standby_select & low_speed_on
    & timer_watch_select;
  wire go_from_sub = (cur_mode == PMD_MODE_SUB) & direct_transition_on & standby_select
    & ~low_speed_on & timer_watch_select;

  // Clock period in force: the new system clock once the oscillator runs again.
  function automatic logic [7:0] period_of(input pmd_mode_e m);
    case (m)
      PMD_MODE_HIGH: period_of = PMD_PER_HIGH;
      PMD_MODE_MED: period_of = PMD_PER_MED;
      default: period_of = PMD_PER_SUB;
    endcase
  endfunction : period_of

  // The divider reloads with the period of the state being entered, so the first wait or
  // exception state already runs at the new clock instead of one old period late.
  // Leaving standby always resumes at high speed, whatever the stopped mode decodes to.
  wire use_new = (next_state == PMD_ST_OSC) | (next_state == PMD_ST_EXC);
  wire from_standby = state == PMD_ST_STANDBY;
  assign period = use_new ? period_of(target_mode)
    : from_standby ? PMD_PER_HIGH : period_of(cur_mode);
  // Watch and standby stop the internal clock, so no state ticks there.
  wire clocks_stopped = (state == PMD_ST_WATCH) | (state == PMD_ST_STANDBY);
  assign tick = ~clocks_stopped & (div_count == 8'h00);

  // Divider producing one-cycle state enables at the period in force.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_count <= 8'h00;
    end else if (clocks_stopped || div_count == 8'h00) begin
      div_count <= period - 8'h01;
    end else begin
      div_count <= div_count - 8'h01;
    end
  end

  // Oscillator wait length in states from the select field.
  wire [PMD_WAIT_W-1:0] osc_wait_states =
    PMD_WAIT_W'(OSC_WAIT_BASE) << osc_wait_select;
  wire [PMD_WAIT_W-1:0] sleep_states =
    PMD_WAIT_W'(PMD_SLEEP_STATES) + PMD_WAIT_W'(PMD_INTERNAL_STATES);
  wire [PMD_WAIT_W-1:0] exc_states = PMD_WAIT_W'(PMD_EXCEPTION_STATES);
  // A stage ends on the tick that consumes its last state.
  wire count_end = tick & (count == PMD_WAIT_W'(1));
  wire leaving_sub = cur_mode == PMD_MODE_SUB;
  wire standby_wake = wake_pin;

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      PMD_ST_RUN: begin
        if (sleep_cmd && go_standby) begin
          next_state = PMD_ST_STANDBY;
        end else if (sleep_cmd && (go_act_act || go_to_sub || go_from_sub)) begin
          next_state = PMD_ST_SLEEP;
        end
      end
      PMD_ST_SLEEP: begin
        if (count_end && target_mode == PMD_MODE_SUB) begin
          next_state = PMD_ST_WATCH;
        end else if (count_end && leaving_sub) begin
          next_state = PMD_ST_WATCH;
        end else if (count_end) begin
          next_state = PMD_ST_EXC;
        end
      end
      PMD_ST_WATCH: begin
        // One clock-stopped cycle; leaving subactive restarts the oscillator.
        next_state = leaving_sub ? PMD_ST_OSC : PMD_ST_EXC;
      end
      PMD_ST_OSC: begin
        if (count_end) begin
          next_state = PMD_ST_EXC;
        end
      end
      PMD_ST_EXC: begin
        if (count_end) begin
          next_state = PMD_ST_RUN;
        end
      end
      PMD_ST_STANDBY: begin
        if (standby_wake) begin
          next_state = PMD_ST_RUN;
        end
      end
      default: next_state = PMD_ST_RUN;
    endcase
  end

  // Entry strobes reload the state counter for the stage that starts.
  wire enter_exc = (next_state == PMD_ST_EXC) & (state != PMD_ST_EXC);
  wire enter_osc = (next_state == PMD_ST_OSC) & (state != PMD_ST_OSC);

  // Sequencer registers: state, counter, modes.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= PMD_ST_RUN;
      count <= '0;
      cur_mode <= PMD_MODE_HIGH;
      target_mode <= PMD_MODE_HIGH;
    end else begin
      state <= next_state;
      if (state == PMD_ST_RUN && next_state == PMD_ST_SLEEP) begin
        count <= sleep_states;
        if (go_to_sub) begin
          target_mode <= PMD_MODE_SUB;
        end else begin
          target_mode <= medium_speed_on ? PMD_MODE_MED : PMD_MODE_HIGH;
        end
      end else if (enter_osc) begin
        count <= osc_wait_states;
      end else if (enter_exc) begin
        count <= exc_states;
      end else if (tick && count != '0) begin
        count <= count - PMD_WAIT_W'(1);
      end
      if (next_state == PMD_ST_STANDBY) begin
        cur_mode <= PMD_MODE_STANDBY;
      end else if (state == PMD_ST_STANDBY) begin
        cur_mode <= PMD_MODE_HIGH;
      end else if (enter_osc || enter_exc) begin
        cur_mode <= target_mode;
      end
    end
  end

  // Event strobes for the status register; each lasts exactly one cycle.
  assign done_pulse = (state == PMD_ST_EXC) & (next_state == PMD_ST_RUN);
  assign wake_pulse = (state == PMD_ST_STANDBY) & standby_wake;

  // Input capture on the eleven clock-stopped sensitive inputs.
  assign raw_inputs = {event_counter_request, wakeup_input, external_request};
  genvar gi;
  generate
    for (gi = 0; gi < PMD_NUM_INPUTS; gi++) begin : g_cap
      pmd_level_capture u_cap (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .pin_in(raw_inputs[gi]),
        .level(in_level[gi]),
        .fall(in_fall[gi])
      );
    end
  endgenerate

  // In standby the filters are frozen, so a raw low on an input whose last level was high wakes us.
  // A pin that is already low on entry cannot wake the device; software checks it first.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_raw <= '1;
    end else if (state != PMD_ST_STANDBY) begin
      last_raw <= in_level;
    end
  end
  assign wake_pin = |(last_raw & ~raw_inputs);

  // Halt bits are applied only at a tick so an enable never cuts a clock pulse short.
  // The price is that a halt write takes effect one to two periods late, from the second tick after it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halt_applied <= {PMD_HALT_RST, PMD_HALT_RST};
    end else if (tick) begin
      halt_applied <= {module_clock_halt_second, module_clock_halt_first};
    end
  end
  assign module_clock_enable = {2*HALT_W{tick}} & halt_applied;
  assign cpu_clock_enable = tick & ~(state == PMD_ST_STANDBY);

  // Pins float in standby unless their pull-up holds them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_float <= '0;
    end else begin
      pin_float <= (next_state == PMD_ST_STANDBY) ? ~pin_pullup_on : '0;
    end
  end

  // The system oscillator runs at both active speeds and while it settles on the way out of
  // subactive; the exception states that finish a move into subactive run on the subclock.
  wire osc_keeps = (next_state == PMD_ST_RUN) | (next_state == PMD_ST_SLEEP);
  wire next_osc_on = (next_state == PMD_ST_OSC)
    | ((next_state == PMD_ST_EXC) & (target_mode != PMD_MODE_SUB))
    | (osc_keeps & (cur_mode != PMD_MODE_SUB));

  // Status outputs; the program keeps running through every direct transition.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_running <= 1'b1;
      system_osc_on <= 1'b1;
      watch_active <= 1'b0;
      exception_start <= 1'b0;
      mode <= 3'h0;
    end else begin
      cpu_running <= next_state != PMD_ST_STANDBY;
      system_osc_on <= next_osc_on;
      watch_active <= next_state == PMD_ST_WATCH;
      exception_start <= enter_exc;
      mode <= cur_mode;
    end
  end

  // Software registers with write-one-to-clear status; a new event beats its clear.
  wire [PMD_IRQ_W-1:0] irq_events = {in_fall, wake_pulse, done_pulse};
  wire [PMD_IRQ_W-1:0] irq_clear = (wr & hit_stat) ? pwdata[PMD_IRQ_W-1:0] : '0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      system_control_first <= PMD_CTRL_RST;
      module_clock_halt_first <= PMD_HALT_RST;
      module_clock_halt_second <= PMD_HALT_RST;
      irq_mask <= '0;
      irq_status <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        system_control_first <= pwdata[7:0];
      end
      if (wr && hit_halt1) begin
        module_clock_halt_first <= pwdata[HALT_W-1:0];
      end
      if (wr && hit_halt2) begin
        module_clock_halt_second <= pwdata[HALT_W-1:0];
      end
      if (wr && hit_mask) begin
        irq_mask <= pwdata[PMD_IRQ_W-1:0];
      end
      irq_status <= (irq_status & ~irq_clear) | irq_events;
    end
  end
  // A plain level: it stays high until software clears every unmasked status bit.
  assign irq = |(irq_status & irq_mask);

  // Read data mux, driven combinationally from the address.
  wire [31:0] rd_ctrl = {24'h000000, system_control_first};
  wire [31:0] rd_halt1 = {{(32-HALT_W){1'b0}}, module_clock_halt_first};
  wire [31:0] rd_halt2 = {{(32-HALT_W){1'b0}}, module_clock_halt_second};
  wire [31:0] rd_mode = {26'h0000000, state, cur_mode};
  wire [31:0] rd_stat = {{(32-PMD_IRQ_W){1'b0}}, irq_status};
  wire [31:0] rd_mask = {{(32-PMD_IRQ_W){1'b0}}, irq_mask};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_halt1 ? rd_halt1 : hit_halt2 ? rd_halt2
    : hit_mode ? rd_mode : hit_stat ? rd_stat : hit_mask ? rd_mask : 32'h00000000;
  assign prdata = rd_mux;
endmodule : pmd_power_mode

// ===== tb/pmd_ext_source.sv
// Partner model: external logic driving request, wake-up and event counter lines.
module pmd_ext_source
  import pmd_pkg::*;
(
  input wire logic clock,
  output logic [1:0] external_request,
  output logic [7:0] wakeup_input,
  output logic event_counter_request
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmd_pkg::*;
  logic [PMD_NUM_INPUTS-1:0] lines = '1;
  // Line order follows the capture status bits: requests, wake-ups, event counter.
  assign external_request = lines[1:0];
  assign wakeup_input = lines[9:2];
  assign event_counter_request = lines[10];
  // Each level is held for the given cycles; callers keep two ticks or more unless testing.
  task automatic drive(input int idx, input logic val, input int hold);
    @(posedge clock);
    lines[idx] <= val;
    repeat (hold) @(posedge clock);
  endtask : drive
endmodule : pmd_ext_source

// ===== tb/pmd_power_mode_monitor.sv
// Checker of the power mode block port behaviour.
module pmd_power_mode_monitor
  import pmd_pkg::*;
#(
  parameter int NUM_PINS = 16,
  parameter int HALT_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pready,
  input wire logic [NUM_PINS-1:0] pin_pullup_on,
  input wire logic [NUM_PINS-1:0] pin_float,
  input wire logic [2*HALT_W-1:0] module_clock_enable,
  input wire logic cpu_clock_enable,
  input wire logic cpu_running,
  input wire logic system_osc_on,
  input wire logic watch_active,
  input wire logic exception_start,
  input wire logic [2:0] mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmd_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Mode decodes; the mode output trails the other registered outputs by a cycle, hence the past terms.
  wire in_standby = mode == PMD_MODE_STANDBY;
  wire in_sub = mode == PMD_MODE_SUB;
  apb_ready_a: assert property (pready)
    else $error("pready low");
  exc_pulse_a: assert property (exception_start |=> !exception_start)
    else $error("exception start longer than one cycle");
  exc_running_a: assert property (exception_start |-> cpu_running)
    else $error("program stopped at exception start");
  standby_stop_a: assert property (!cpu_running |-> !cpu_clock_enable)
    else $error("cpu clock runs in standby");
  watch_stop_a: assert property (watch_active |-> !cpu_clock_enable)
    else $error("cpu clock runs during watch pass");
  standby_float_a: assert property (!cpu_running
    |-> pin_float == ~$past(pin_pullup_on)) else $error("pin float wrong in standby");
  standby_mode_a: assert property (in_standby && $past(in_standby)
    |-> !$past(cpu_running)) else $error("standby mode shown while program runs");
  run_drive_a: assert property (cpu_running && $past(cpu_running)
    |-> pin_float == '0) else $error("pins float while running");
  sub_osc_a: assert property (in_sub && $past(in_sub) |-> !$past(system_osc_on))
    else $error("system oscillator on in subactive");
  gate_pulse_a: assert property (|module_clock_enable
    |=> (module_clock_enable & $past(module_clock_enable)) == '0)
    else $error("module clock enable wider than one cycle");
endmodule : pmd_power_mode_monitor

// ===== tb/tb_pmd_power_mode.sv
// Testbench of the power mode direct transition block.
module tb_pmd_power_mode;
  timeunit 1ns;
  timeprecision 1ps;
  import pmd_pkg::*;
  localparam int NUM_PINS = 16;
  localparam int HALT_W = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [NUM_PINS-1:0] pin_pullup_on = '0;
  logic [31:0] prdata, rq;
  logic pready, pslverr, re, cpu_clock_enable, cpu_running, system_osc_on;
  logic watch_active, exception_start, irq, event_counter_request;
  logic saw_watch = 1'b0;
  logic [1:0] external_request;
  logic [7:0] wakeup_input;
  logic [NUM_PINS-1:0] pin_float;
  logic [2*HALT_W-1:0] module_clock_enable;
  logic [2:0] mode;
  int bad_count = 0;
  int num_checks = 0;
  // A short oscillator wait keeps the run brief.
  pmd_power_mode #(.OSC_WAIT_BASE(4), .NUM_PINS(NUM_PINS), .HALT_W(HALT_W)) i_dut (.*);
  pmd_ext_source i_src (.*);
  // Clock, and a marker of the watch pass that scenarios clear.
  always #20 clock = ~clock;
  always @(posedge clock) if (watch_active === 1'b1) saw_watch <= 1'b1;
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rq);
  endtask : rchk
  // Waits are ended by the watchdog if the design never answers.
  task automatic wait_exc(output int n);
    n = 0;
    while (exception_start !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_exc
  task automatic poll_done(output int n);
    n = 0;
    do begin
      apb(1'b0, PMD_OFF_IRQ_STAT, 32'h0);
      n += 3;
    end while (rq[PMD_IRQ_DONE] !== 1'b1);
    apb(1'b1, PMD_OFF_IRQ_STAT, 32'h1);
  endtask : poll_done
  task automatic count_en(input int b, output int c);
    c = 0;
    repeat (32) begin
      @(posedge clock);
      if (module_clock_enable[b] === 1'b1) c++;
    end
  endtask : count_en
  task automatic t_regs();
    rchk("ctrl", PMD_OFF_CTRL, {24'h0, PMD_CTRL_RST});
    rchk("halt1", PMD_OFF_HALT1, {24'h0, PMD_HALT_RST});
    rchk("halt2", PMD_OFF_HALT2, {24'h0, PMD_HALT_RST});
    rchk("mode", PMD_OFF_MODE, 32'h0);
    apb(1'b1, 8'h1c, 32'h1);
    chk("unmapped write err", 32'h1, {31'h0, re});
    rchk("unmapped read", 8'h1c, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, re});
  endtask : t_regs
  // High speed ticks every 2 cycles, so 32 cycles give 16 pulses.
  task automatic t_halt();
    int c;
    apb(1'b1, PMD_OFF_HALT1, 32'hfe);
    apb(1'b1, PMD_OFF_HALT2, 32'h7f);
    rchk("halt1 back", PMD_OFF_HALT1, 32'hfe);
    count_en(0, c);
    chk("halted bit0", 0, c);
    count_en(15, c);
    chk("halted bit15", 0, c);
    count_en(1, c);
    chk("running bit1", 16, c);
    apb(1'b1, PMD_OFF_HALT1, 32'hff);
    apb(1'b1, PMD_OFF_HALT2, 32'hff);
    count_en(0, c);
    chk("resumed bit0", 16, c);
  endtask : t_halt
  // Medium period 16 cycles for 3 states, then 14 states at 2 cycles.
  task automatic t_direct();
    int n;
    apb(1'b1, PMD_OFF_CTRL, 32'h18);
    apb(1'b1, PMD_OFF_SLEEP, 32'h1);
    poll_done(n);
    chk("mode medium", PMD_MODE_MED, mode);
    apb(1'b1, PMD_OFF_CTRL, 32'h08);
    apb(1'b1, PMD_OFF_SLEEP, 32'h1);
    wait_exc(n);
    chk("sleep span", 1, n inside {[30:60]});
    chk("running", 1, cpu_running);
    poll_done(n);
    chk("exception span", 1, n inside {[24:40]});
    chk("mode high", PMD_MODE_HIGH, mode);
  endtask : t_direct
  // Subclock period 64; the way back adds 4 wait states at 2 cycles.
  task automatic t_sub();
    int n;
    apb(1'b1, PMD_OFF_CTRL, 32'h0f);
    saw_watch = 1'b0;
    apb(1'b1, PMD_OFF_SLEEP, 32'h1);
    poll_done(n);
    chk("watch into sub", 1, saw_watch);
    chk("mode sub", PMD_MODE_SUB, mode);
    chk("osc stopped", 0, system_osc_on);
    apb(1'b1, PMD_OFF_CTRL, 32'h0d);
    saw_watch = 1'b0;
    apb(1'b1, PMD_OFF_SLEEP, 32'h1);
    wait_exc(n);
    chk("sub span", 1, n inside {[130:215]});
    chk("osc running", 1, system_osc_on);
    chk("watch out of sub", 1, saw_watch);
    poll_done(n);
    chk("mode high after sub", PMD_MODE_HIGH, mode);
  endtask : t_sub
  task automatic t_standby();
    pin_pullup_on <= 16'h00ff;
    apb(1'b1, PMD_OFF_CTRL, 32'h01);
    apb(1'b1, PMD_OFF_SLEEP, 32'h1);
    while (cpu_running !== 1'b0) @(posedge clock);
    repeat (4) @(posedge clock);
    chk("standby mode", PMD_MODE_STANDBY, mode);
    chk("pins float", 32'hff00, pin_float);
    i_src.drive(3, 1'b0, 16);
    while (cpu_running !== 1'b1) @(posedge clock);
    i_src.drive(3, 1'b1, 16);
    chk("mode after wake", PMD_MODE_HIGH, mode);
    chk("pins driven", 0, pin_float);
    apb(1'b0, PMD_OFF_IRQ_STAT, 32'h0);
    chk("wake status", 1, rq[PMD_IRQ_WAKE]);
    apb(1'b1, PMD_OFF_IRQ_STAT, 32'h1fff);
  endtask : t_standby
  task automatic t_capture();
    logic i1;
    for (int i = 0; i < PMD_NUM_INPUTS; i++) begin
      i_src.drive(i, 1'b0, 8);
      i_src.drive(i, 1'b1, 8);
      rchk("captured fall", PMD_OFF_IRQ_STAT, 32'h1 << (PMD_IRQ_CAP + i));
      apb(1'b1, PMD_OFF_IRQ_STAT, 32'h1 << (PMD_IRQ_CAP + i));
    end
    i_src.drive(0, 1'b0, 16);
    apb(1'b1, PMD_OFF_IRQ_MASK, 32'h1fff);
    @(posedge clock);
    i1 = irq;
    apb(1'b1, PMD_OFF_IRQ_MASK, 32'h0);
    @(posedge clock);
    chk("irq unmasked", 1, i1);
    chk("irq masked", 0, irq);
    apb(1'b1, PMD_OFF_IRQ_STAT, 32'h1fff);
    i_src.drive(0, 1'b1, 1);
    i_src.drive(0, 1'b0, 16);
    rchk("short high ignored", PMD_OFF_IRQ_STAT, 32'h0);
    i_src.drive(0, 1'b1, 16);
    apb(1'b1, PMD_OFF_IRQ_MASK, 32'h1fff);
    @(posedge clock);
    chk("irq cleared", 0, irq);
  endtask : t_capture
  // Main sequence; the run takes a few thousand cycles, far below the watchdog.
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_halt();
    t_direct();
    t_sub();
    t_standby();
    t_capture();
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_pmd_power_mode
bind pmd_power_mode pmd_power_mode_monitor #(.NUM_PINS(NUM_PINS), .HALT_W(HALT_W)) i_mon (.*);
